// ### hdl/flash_read_pkg.sv
// Shared constants, opcodes and helpers for the serial flash read path
package flash_read_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_LEGACY = 8'hE8;
	localparam logic [7:0] OP_FAST   = 8'h0B;
	localparam logic [7:0] OP_SLOW   = 8'h03;
	localparam logic [7:0] OP_PAGE   = 8'hD2;

	// ****************************************
	// Array geometry and field positions
	// ****************************************
	localparam int          PAGE_COUNT    = 512;
	localparam int          ARRAY_BYTES   = 135168;
	localparam logic [17:0] PAGE_STRIDE   = 18'h0_0108;
	localparam logic [8:0]  BYTE_LAST_STD = 9'h107;
	localparam logic [8:0]  BYTE_LAST_BIN = 9'h0FF;
	localparam int          STD_PAGE_LSB  = 9;
	localparam int          BIN_PAGE_LSB  = 8;
	localparam logic [5:0]  OPC_LAST_BIT  = 6'h07;
	localparam logic [5:0]  ADDR_LAST_BIT = 6'h17;
	localparam logic [6:0]  HDR_BASE_BITS = 7'h20;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ               = 200;
	localparam int FAST_READ_CLOCK_LIMIT = 66;
	localparam int SLOW_READ_CLOCK_LIMIT = 33;
	localparam int SCK_HALF_MIN_CYCLES   =
		(CLK_MHZ + 2 * SLOW_READ_CLOCK_LIMIT - 1) / (2 * SLOW_READ_CLOCK_LIMIT);
	localparam int SYNC_MARGIN_CYCLES    = 6;
	localparam int SCK_HALF_CYCLES       = 8;

	// Don't-care bytes that follow the address for each read opcode
	function automatic logic [2:0] dummy_bytes(input logic [7:0] op);
		case (op)
		OP_LEGACY, OP_PAGE: dummy_bytes = 3'h4;
		OP_FAST:            dummy_bytes = 3'h1;
		default:            dummy_bytes = 3'h0;
		endcase
	endfunction

	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == OP_LEGACY) || (op == OP_FAST) || (op == OP_SLOW) || (op == OP_PAGE);
	endfunction

endpackage

// ### hdl/flash_link_if.sv
// Serial link between the flash host and the flash device
`timescale 1ns/100ps
interface flash_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;

	// Undriven output floats high through the board pull-up
	assign so_line = so_oe ? so : 1'b1;

	modport dev (input cs_n, input sck, input si, output so, output so_oe);
	modport host (output cs_n, output sck, output si, input so_line);
endinterface

// ### hdl/link_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module link_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_chk
		$error("link_fifo: depth must be a power of two of at least 2");
	end

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0]   count_reg;
	logic [AW:0]   count_next;
	logic          push;
	logic          pop;
	logic [AW-1:0] rptr_next;

	assign push      = in_valid_i && in_ready_o;
	assign pop       = out_ready_i && out_valid_o;
	assign rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr_reg] <= in_data_i;
		end
	end

	// Head word held in a flop; a push into an emptied FIFO bypasses memory
	always_ff @(posedge clk_i) begin
		if (push && wptr_reg == rptr_next) begin
			out_data_o <= in_data_i;
		end else begin
			out_data_o <= mem[rptr_next];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr_reg    <= '0;
			rptr_reg    <= '0;
			count_reg   <= '0;
			out_valid_o <= 1'b0;
			in_ready_o  <= 1'b0;
		end else begin
			wptr_reg    <= push ? wptr_reg + 1'b1 : wptr_reg;
			rptr_reg    <= pop ? rptr_reg + 1'b1 : rptr_reg;
			count_reg   <= count_next;
			out_valid_o <= count_next != '0;
			in_ready_o  <= count_next != (AW + 1)'(D);
		end
	end
endmodule

// ### hdl/flash_read_dev.sv
// Serial flash device end: main array read commands over the serial link
`timescale 1ns/100ps
// ****************************************
// ****************************************
module flash_read_dev (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	flash_link_if.dev        link,
	input  wire logic        page_256_i,
	input  wire logic        mem_we_i,
	input  wire logic [17:0] mem_addr_i,
	input  wire logic [7:0]  mem_wdata_i,
	output logic             reading_o
);
	typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} dev_state_t;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic cs_s1;
	logic cs_s2;
	logic sck_s1;
	logic sck_s2;
	logic sck_s3;
	logic si_s1;
	logic si_s2;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			si_s1  <= 1'b0;
			si_s2  <= 1'b0;
		end else begin
			cs_s1  <= link.cs_n;
			cs_s2  <= cs_s1;
			sck_s1 <= link.sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			si_s1  <= link.si;
			si_s2  <= si_s1;
		end
	end

	// Edges of the synchronised clock; the mode is implied by idle level
	logic rise_in;
	logic fall_in;
	assign rise_in = !cs_s2 && sck_s2 && !sck_s3;
	assign fall_in = !cs_s2 && !sck_s2 && sck_s3;

	// ****************************************
	// Command sequencer
	// ****************************************
	dev_state_t  state_reg;
	logic [5:0]  cnt_reg;
	logic [7:0]  op_reg;
	logic [23:0] hdr_sh_reg;
	logic [7:0]  op_word;
	logic [23:0] addr_word;
	logic [5:0]  dummy_last;
	logic        addr_load;

	assign op_word    = {hdr_sh_reg[6:0], si_s2};
	assign addr_word  = {hdr_sh_reg[22:0], si_s2};
	assign dummy_last = {flash_read_pkg::dummy_bytes(op_reg), 3'h7} - 6'h08;
	assign addr_load  = rise_in && state_reg == D_ADDR && cnt_reg == flash_read_pkg::ADDR_LAST_BIT;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= D_IDLE;
			cnt_reg   <= '0;
			op_reg    <= '0;
		end else if (cs_s2) begin
			state_reg <= D_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
			D_IDLE: begin
				state_reg <= D_OPC;
				cnt_reg   <= '0;
			end
			D_OPC: begin
				if (rise_in) begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == flash_read_pkg::OPC_LAST_BIT) begin
						cnt_reg <= '0;
						op_reg  <= op_word;
						if (flash_read_pkg::op_known(op_word)) begin
							state_reg <= D_ADDR;
						end else begin
							state_reg <= D_IGNORE;
						end
					end
				end
			end
			D_ADDR: begin
				if (rise_in) begin
					cnt_reg <= cnt_reg + 6'h01;
					if (addr_load) begin
						cnt_reg <= '0;
						// Slow read has no dummy byte: data follows at once
						if (flash_read_pkg::dummy_bytes(op_reg) == 3'h0) begin
							state_reg <= D_DATA;
						end else begin
							state_reg <= D_DUMMY;
						end
					end
				end
			end
			D_DUMMY: begin
				if (rise_in) begin
					cnt_reg <= cnt_reg + 6'h01;
					if (cnt_reg == dummy_last) begin
						state_reg <= D_DATA;
					end
				end
			end
			D_DATA: begin
				state_reg <= D_DATA;
			end
			D_IGNORE: begin
				state_reg <= D_IGNORE;
			end
			default: begin
				state_reg <= D_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hdr_sh_reg <= '0;
		end else if (rise_in && (state_reg == D_OPC || state_reg == D_ADDR)) begin
			hdr_sh_reg <= addr_word;
		end
	end

	// ****************************************
	// Read pointer
	// ****************************************
	logic [8:0] page_reg;
	logic [8:0] byte_reg;
	logic [8:0] byte_last;
	logic [8:0] byte_in;
	logic [8:0] page_in;
	logic       byte_start;
	logic [2:0] dbit_reg;

	assign byte_last  = page_256_i ? flash_read_pkg::BYTE_LAST_BIN : flash_read_pkg::BYTE_LAST_STD;
	assign byte_start = fall_in && state_reg == D_DATA && dbit_reg == 3'h0;

	// Upper address bits above the page field are simply not looked at
	always_comb begin
		if (page_256_i) begin
			page_in = addr_word[flash_read_pkg::BIN_PAGE_LSB +: 9];
			byte_in = {1'b0, addr_word[7:0]};
		end else begin
			page_in = addr_word[flash_read_pkg::STD_PAGE_LSB +: 9];
			byte_in = addr_word[8:0];
		end
	end

	// Byte offsets past the page end are clamped to its last byte
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			page_reg <= '0;
			byte_reg <= '0;
		end else if (addr_load) begin
			page_reg <= page_in;
			byte_reg <= (byte_in > byte_last) ? byte_last : byte_in;
		end else if (byte_start) begin
			if (byte_reg >= byte_last) begin
				byte_reg <= '0;
				if (op_reg != flash_read_pkg::OP_PAGE) begin
					page_reg <= page_reg + 9'h001;
				end
			end else begin
				byte_reg <= byte_reg + 9'h001;
			end
		end
	end

	// ****************************************
	// Main array
	// ****************************************
	// No data buffer exists on this path, so nothing here can disturb one
	logic [7:0]  mem [flash_read_pkg::ARRAY_BYTES];
	logic [7:0]  mem_q_reg;
	logic [17:0] mem_idx;

	assign mem_idx = 18'(page_reg * flash_read_pkg::PAGE_STRIDE) + {9'h000, byte_reg};

	always_ff @(posedge clk_i) begin
		if (mem_we_i && mem_addr_i < 18'(flash_read_pkg::ARRAY_BYTES)) begin
			mem[mem_addr_i] <= mem_wdata_i;
		end
	end

	// Prefetch runs every cycle; a new byte is ready long before it is due
	always_ff @(posedge clk_i) begin
		mem_q_reg <= mem[mem_idx];
	end

	// ****************************************
	// Serial output
	// ****************************************
	logic [6:0] out_sh_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link.so    <= 1'b0;
			link.so_oe <= 1'b0;
			out_sh_reg <= '0;
			dbit_reg   <= '0;
		end else if (cs_s2 || state_reg != D_DATA) begin
			link.so_oe <= 1'b0;
			dbit_reg   <= '0;
		end else if (fall_in) begin
			link.so_oe <= 1'b1;
			dbit_reg   <= dbit_reg + 3'h1;
			if (dbit_reg == 3'h0) begin
				link.so    <= mem_q_reg[7];
				out_sh_reg <= mem_q_reg[6:0];
			end else begin
				link.so    <= out_sh_reg[6];
				out_sh_reg <= {out_sh_reg[5:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reading_o <= 1'b0;
		end else begin
			reading_o <= !cs_s2 && state_reg == D_DATA;
		end
	end
endmodule

// ### hdl/flash_read_host.sv
// Serial flash host end: issues read commands and collects the stream
`timescale 1ns/100ps
module flash_read_host #(
	parameter int HALF  = flash_read_pkg::SCK_HALF_CYCLES,
	parameter int DEPTH = 4
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	flash_link_if.host       link,
	input  wire logic        mode3_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [7:0]  cmd_opcode_i,
	input  wire logic [23:0] cmd_addr_i,
	input  wire logic [15:0] cmd_len_i,
	output logic             cmd_ready_o,
	output logic             done_o,
	output logic             rd_valid_o,
	input  wire logic        rd_ready_i,
	output logic [7:0]       rd_data_o
);
	typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_WAIT, H_END, H_GAP} host_state_t;

	// The device needs several cycles to see each edge through its synchronisers
	if (HALF < flash_read_pkg::SCK_HALF_MIN_CYCLES || HALF < flash_read_pkg::SYNC_MARGIN_CYCLES
		|| HALF > 255) begin : g_chk
		$error("flash_read_host: HALF out of range");
	end

	localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

	logic so_s1;
	logic so_s2;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			so_s1 <= 1'b1;
			so_s2 <= 1'b1;
		end else begin
			so_s1 <= link.so_line;
			so_s2 <= so_s1;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	host_state_t state_reg;
	logic [7:0]  half_reg;
	logic [63:0] hdr_reg;
	logic [6:0]  hdr_left_reg;
	logic [19:0] tot_left_reg;
	logic [7:0]  rx_reg;
	logic [2:0]  rbit_reg;
	logic        push_reg;
	logic        cs_n_reg;
	logic        sck_reg;
	logic        si_reg;
	logic        fifo_ready;
	logic        half_end;
	logic        data_bit;
	logic        next_data_start;

	assign half_end        = half_reg == HALF_LAST;
	assign data_bit        = hdr_left_reg == '0;
	assign next_data_start = (hdr_left_reg == 7'h01) || (data_bit && rbit_reg == 3'h7);
	assign link.cs_n       = cs_n_reg;
	assign link.sck        = sck_reg;
	assign link.si         = si_reg;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg    <= H_IDLE;
			half_reg     <= '0;
			hdr_reg      <= '0;
			hdr_left_reg <= '0;
			tot_left_reg <= '0;
			rx_reg       <= '0;
			rbit_reg     <= '0;
			push_reg     <= 1'b0;
			cs_n_reg     <= 1'b1;
			sck_reg      <= 1'b0;
			si_reg       <= 1'b0;
			cmd_ready_o  <= 1'b0;
			done_o       <= 1'b0;
		end else begin
			half_reg <= half_end ? '0 : half_reg + 8'h01;
			push_reg <= 1'b0;
			done_o   <= 1'b0;
			case (state_reg)
			H_IDLE: begin
				sck_reg     <= mode3_i;
				cmd_ready_o <= 1'b1;
				half_reg    <= '0;
				if (cmd_valid_i && cmd_ready_o) begin
					cmd_ready_o  <= 1'b0;
					cs_n_reg     <= 1'b0;
					hdr_reg      <= {cmd_opcode_i, cmd_addr_i, 32'h0000_0000};
					hdr_left_reg <= {1'b0, flash_read_pkg::dummy_bytes(cmd_opcode_i), 3'h0}
						+ flash_read_pkg::HDR_BASE_BITS;
					tot_left_reg <= {14'h0000, flash_read_pkg::dummy_bytes(cmd_opcode_i), 3'h0}
						+ 20'h0_0020 + {1'b0, cmd_len_i, 3'h0};
					rbit_reg     <= '0;
					state_reg    <= H_LEAD;
				end
			end
			H_LEAD, H_WAIT: begin
				// Held high while the FIFO is full: the clock simply pauses
				if ((state_reg == H_LEAD && half_end)
					|| (state_reg == H_WAIT && fifo_ready && !push_reg)) begin
					sck_reg   <= 1'b0;
					si_reg    <= hdr_reg[63];
					hdr_reg   <= {hdr_reg[62:0], 1'b0};
					half_reg  <= '0;
					state_reg <= (tot_left_reg == '0) ? H_END : H_LOW;
				end
			end
			H_LOW: begin
				if (half_end) begin
					sck_reg   <= 1'b1;
					state_reg <= H_HIGH;
				end
			end
			H_HIGH: begin
				if (half_end) begin
					tot_left_reg <= tot_left_reg - 20'h0_0001;
					if (data_bit) begin
						rx_reg   <= {rx_reg[6:0], so_s2};
						rbit_reg <= rbit_reg + 3'h1;
						push_reg <= rbit_reg == 3'h7;
					end else begin
						hdr_left_reg <= hdr_left_reg - 7'h01;
					end
					if (tot_left_reg == 20'h0_0001) begin
						state_reg <= H_END;
					end else if (next_data_start) begin
						state_reg <= H_WAIT;
					end else begin
						sck_reg   <= 1'b0;
						si_reg    <= hdr_reg[63];
						hdr_reg   <= {hdr_reg[62:0], 1'b0};
						state_reg <= H_LOW;
					end
				end
			end
			H_END: begin
				sck_reg <= mode3_i;
				if (half_end) begin
					cs_n_reg  <= 1'b1;
					done_o    <= 1'b1;
					state_reg <= H_GAP;
				end
			end
			H_GAP: begin
				if (half_end) begin
					state_reg <= H_IDLE;
				end
			end
			default: begin
				state_reg <= H_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// Read data buffer
	// ****************************************
	link_fifo #(
		.W (8),
		.D (DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (push_reg),
		.in_ready_o  (fifo_ready),
		.in_data_i   (rx_reg),
		.out_valid_o (rd_valid_o),
		.out_ready_i (rd_ready_i),
		.out_data_o  (rd_data_o)
	);
endmodule

// ### verification/flash_read_asserts.sv
// Concurrent checks on the serial flash link between host and device
`timescale 1ns/100ps
module flash_read_asserts (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic so_line
);
	logic        sck_reg;
	logic [15:0] rise_reg;
	logic [7:0]  op_reg;
	logic [7:0]  age_reg;
	logic [7:0]  hdr;
	logic        rise;
	logic        known;

	// ****************************************
	// Helper logic
	// ****************************************
	assign rise = sck && !sck_reg;
	assign known = op_reg == flash_read_pkg::OP_LEGACY || op_reg == flash_read_pkg::OP_FAST ||
		op_reg == flash_read_pkg::OP_SLOW || op_reg == flash_read_pkg::OP_PAGE;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_reg <= 1'b0;
			age_reg <= 8'h00;
		end else begin
			sck_reg <= sck;
			if (sck != sck_reg) begin
				age_reg <= 8'h00;
			end else if (age_reg != 8'hFF) begin
				age_reg <= age_reg + 8'h01;
			end
		end
	end

	// Opcode shifted off the wire, so header length is known per frame
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rise_reg <= 16'h0000;
			op_reg <= 8'h00;
		end else if (cs_n) begin
			rise_reg <= 16'h0000;
		end else if (rise) begin
			rise_reg <= rise_reg + 16'h0001;
			if (rise_reg < 16'h0008) begin
				op_reg <= {op_reg[6:0], si};
			end
		end
	end

	always_comb begin
		case (op_reg)
		flash_read_pkg::OP_LEGACY, flash_read_pkg::OP_PAGE: hdr = 8'h40;
		flash_read_pkg::OP_FAST: hdr = 8'h28;
		default: hdr = 8'h20;
		endcase
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_deselect; $rose(cs_n); endsequence
	sequence s_select; $fell(cs_n); endsequence
	sequence s_driving; (so_oe && !cs_n) ##1 !cs_n; endsequence

	property p_release; s_deselect |-> ##[1:6] !so_oe; endproperty
	property p_idle_off; cs_n [*8] |-> !so_oe; endproperty
	property p_frame; s_select |-> !cs_n [*8]; endproperty
	property p_so_low; (so_oe && $past(so_oe) && !cs_n && $changed(so)) |-> !sck; endproperty
	property p_first; $rose(so_oe) |-> rise_reg == {8'h00, hdr}; endproperty
	property p_unknown; (!cs_n && rise_reg >= 16'h0008 && !known) |-> !so_oe; endproperty
	property p_stream; s_driving |-> so_oe; endproperty
	property p_sck_half; (!cs_n && sck != sck_reg) |-> age_reg >= 8'h05; endproperty
	property p_line_idle; cs_n [*8] |-> so_line; endproperty

	a_release: assert property (p_release) else $error("so driven after deselect");
	a_idle_off: assert property (p_idle_off) else $error("so driven while idle");
	a_frame: assert property (p_frame) else $error("select pulse too short");
	a_so_low: assert property (p_so_low) else $error("so moved in sck high");
	a_first: assert property (p_first) else $error("first data bit misplaced");
	a_unknown: assert property (p_unknown) else $error("so driven for unknown opcode");
	a_stream: assert property (p_stream) else $error("stream paused");
	a_sck_half: assert property (p_sck_half) else $error("sck phase too short");
	a_line_idle: assert property (p_line_idle) else $error("so line not released");
endmodule

// ### verification/serial_flash_array_read_tb.sv
// Self-checking bench: host and device ends joined over the serial link
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	cmp_count++; \
	if ((got) !== (ex)) begin \
		mismatches++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
	end
module serial_flash_array_read_tb;
	logic        clk_i;
	logic        nrst_i;
	logic        page_256_i;
	logic        mem_we_i;
	logic [17:0] mem_addr_i;
	logic [7:0]  mem_wdata_i;
	logic        reading_o;
	logic        mode3_i;
	logic        cmd_valid_i;
	logic [7:0]  cmd_opcode_i;
	logic [23:0] cmd_addr_i;
	logic [15:0] cmd_len_i;
	logic        cmd_ready_o;
	logic        done_o;
	logic        rd_valid_o;
	logic        rd_ready_i;
	logic [7:0]  rd_data_o;
	logic        cs_w;
	logic        sck_w;
	logic        oe_w;
	logic        line_w;
	logic        sck_q;
	logic [7:0]  wire_op;
	int          mismatches;
	int          cmp_count;
	int          cycles;
	int          done_cnt;
	int          oe_cnt;
	int          bit_cnt;

	flash_link_if flash_link_if_inst ();
	flash_read_dev flash_read_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(flash_link_if_inst),
		.page_256_i(page_256_i), .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i),
		.mem_wdata_i(mem_wdata_i), .reading_o(reading_o));
	// Smallest safe half period keeps the run short
	flash_read_host #(.HALF(6), .DEPTH(4)) flash_read_host_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.link(flash_link_if_inst), .mode3_i(mode3_i), .cmd_valid_i(cmd_valid_i),
		.cmd_opcode_i(cmd_opcode_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .rd_valid_o(rd_valid_o),
		.rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o));
	flash_read_asserts flash_read_asserts_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n(cs_w),
		.sck(sck_w), .si(flash_link_if_inst.si), .so(flash_link_if_inst.so), .so_oe(oe_w),
		.so_line(line_w));

	assign cs_w = flash_link_if_inst.cs_n;
	assign sck_w = flash_link_if_inst.sck;
	assign oe_w = flash_link_if_inst.so_oe;
	assign line_w = flash_link_if_inst.so_line;

	always #2.5 clk_i = ~clk_i;

	// ****************************************
	// Wire monitor and timeout
	// ****************************************
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		sck_q <= sck_w;
		if (done_o === 1'b1) done_cnt <= done_cnt + 1;
		if (oe_w === 1'b1) oe_cnt <= oe_cnt + 1;
		if (cs_w !== 1'b0) begin
			bit_cnt <= 0;
		end else if (sck_w && !sck_q) begin
			bit_cnt <= bit_cnt + 1;
			if (bit_cnt < 8) wire_op <= {wire_op[6:0], flash_link_if_inst.si};
		end
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end

	function automatic logic [7:0] pat(input logic [17:0] i);
		pat = i[7:0] ^ i[15:8] ^ {6'h00, i[17:16]} ^ 8'h5A;
	endfunction

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Preload the bytes to be read, issue one read, collect and compare
	task automatic run(input logic [7:0] op, input logic [8:0] pg0, input logic [8:0] by0,
		input logic m256, input logic m3, input int len, input int stall);
		logic [7:0]  expq[$];
		logic [8:0]  pg;
		logic [8:0]  by;
		logic [17:0] idx;
		logic        kn;
		int          n;
		int          w;
		int          d0;
		int          o0;
		pg = pg0;
		by = by0;
		kn = op == flash_read_pkg::OP_LEGACY || op == flash_read_pkg::OP_FAST ||
			op == flash_read_pkg::OP_SLOW || op == flash_read_pkg::OP_PAGE;
		for (n = 0; n < len; n++) begin
			idx = {9'h000, pg} * flash_read_pkg::PAGE_STRIDE + {9'h000, by};
			expq.push_back(kn ? pat(idx) : 8'hFF);
			@(posedge clk_i);
			mem_we_i <= kn;
			mem_addr_i <= idx;
			mem_wdata_i <= pat(idx);
			if (by == (m256 ? flash_read_pkg::BYTE_LAST_BIN : flash_read_pkg::BYTE_LAST_STD)) begin
				by = 9'h000;
				if (op != flash_read_pkg::OP_PAGE) pg = pg + 9'h001;
			end else begin
				by = by + 9'h001;
			end
		end
		@(posedge clk_i);
		mem_we_i <= 1'b0;
		page_256_i <= m256;
		mode3_i <= m3;
		rd_ready_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		w = 0;
		while (cmd_ready_o !== 1'b1 && w < 4000) begin
			@(negedge clk_i);
			w++;
		end
		@(posedge clk_i);
		cmd_valid_i <= 1'b1;
		cmd_opcode_i <= op;
		// Junk in the unused leading bits
		cmd_addr_i <= m256 ? {7'h55, pg0, by0[7:0]} : {6'h2A, pg0, by0};
		cmd_len_i <= 16'(len);
		d0 = done_cnt;
		o0 = oe_cnt;
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		if (stall > 0) begin
			repeat (stall) @(negedge clk_i);
			`CHK("select held", 1'b0, cs_w)
			`CHK("data phase", 1'b1, reading_o)
			`CHK("fifo holding", 1'b1, rd_valid_o)
		end
		@(posedge clk_i);
		rd_ready_i <= 1'b1;
		n = 0;
		w = 0;
		while (n < len && w < 20000) begin
			@(negedge clk_i);
			w++;
			if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
				`CHK("read byte", expq[n], rd_data_o)
				n++;
			end
		end
		w = 0;
		while (cmd_ready_o !== 1'b1 && w < 4000) begin
			@(negedge clk_i);
			w++;
		end
		`CHK("byte count", len, n)
		`CHK("done pulses", d0 + 1, done_cnt)
		`CHK("opcode on wire", op, wire_op)
		`CHK("sck idle level", m3, sck_w)
		`CHK("so released", 1'b1, line_w)
		`CHK("data phase over", 1'b0, reading_o)
		`CHK("so driven", kn, oe_cnt != o0)
		$display("test opcode %h page %0d byte %0d done", op, pg0, by0);
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		nrst_i = 1'b0;
		page_256_i = 1'b0;
		mem_we_i = 1'b0;
		mem_addr_i = 18'h0_0000;
		mem_wdata_i = 8'h00;
		mode3_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_opcode_i = 8'h00;
		cmd_addr_i = 24'h00_0000;
		cmd_len_i = 16'h0000;
		rd_ready_i = 1'b0;
		sck_q = 1'b0;
		wire_op = 8'h00;
		mismatches = 0;
		cmp_count = 0;
		cycles = 0;
		done_cnt = 0;
		oe_cnt = 0;
		bit_cnt = 0;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		run(flash_read_pkg::OP_LEGACY, 9'h005, 9'h106, 1'b0, 1'b0, 4, 0);
		run(flash_read_pkg::OP_FAST, 9'h1FF, 9'h0FE, 1'b1, 1'b1, 4, 0);
		run(flash_read_pkg::OP_SLOW, 9'h1FF, 9'h106, 1'b0, 1'b0, 3, 0);
		run(flash_read_pkg::OP_PAGE, 9'h007, 9'h106, 1'b0, 1'b1, 4, 0);
		run(flash_read_pkg::OP_PAGE, 9'h003, 9'h0FF, 1'b1, 1'b0, 2, 0);
		run(8'h9F, 9'h002, 9'h000, 1'b0, 1'b0, 2, 0);
		run(flash_read_pkg::OP_LEGACY, 9'h064, 9'h000, 1'b0, 1'b0, 10, 2500);
		close_out();
	end
endmodule
